// ==== hw/idq_register_window.sv ====
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Decode sixteen bytes above switch-selected base
// [RQ2] Offsets 0-2 counters, 3 control write-only
// [RQ3] Offsets 4,5 read result and flag
// [RQ4] Not-ready flag clears when conversion completes
// [RQ5] Offsets 4,5 load first converter channel
// [RQ6] Offsets 6,7 load second converter channel
// [RQ7] Output latch updates on high-part write
// [RQ8] Host writes low byte before high byte
// [RQ9] Offsets 6,7 read sixteen digital inputs
// [RQ10] Interrupt mode sets done bit, raises request
// [RQ11] Write to offset 8 clears done bit
// [RQ12] Write-only offsets 9-14; reads 8-15 reserved
// [RQ13] Trigger source internal or external pin
// [RQ14] Counters one and two cascade as pacer
// [RQ15] User counter clock internal or external
// [RQ16] Write to offset 12 starts one conversion
// [RQ17] Offset 10 low nibble selects channel
// [RQ18] Mode bits select trigger and transfer
// [RQ19] Offsets 13,14 latch sixteen digital outputs
// [RQ20] Trigger sets not-ready until new sample; code leaves it clear while an unread result is held
// [RQ21] Reserved reads zero, reserved writes ignored
module idq_register_window
  import idq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host I/O bus
  input wire logic [9:0] io_addr,
  input wire logic io_aen,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  // Board straps
  input wire logic [5:0] base_select,
  input wire logic trigger_source_jumper,
  input wire logic counter_clock_jumper,
  // Timer pins
  input wire logic external_counter_clock,
  output logic user_counter_out,
  // Converter interface
  input wire logic external_trigger_input,
  output logic adc_start,
  input wire logic adc_done,
  output logic adc_done_ready,
  input wire logic [11:0] adc_data,
  output logic [2:0] gain_code,
  output logic [3:0] channel_select_bits,
  // Analog outputs
  output logic [11:0] dac_first_value,
  output logic [11:0] dac_second_value,
  // Digital lines
  input wire logic [15:0] digital_in,
  output logic [15:0] digital_out,
  // Host service lines
  output logic conversion_irq,
  output logic dma_request
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic prev_read_n;
    logic prev_write_n;
    logic [7:0] rd_data;
    logic [2:0][15:0] reload;
    logic [2:0][15:0] count;
    logic [2:0] wr_high;
    logic [2:0] rd_high;
    logic [2:0][7:0] rd_hold;
    logic [4:0] ref_div;
    logic ext_clk_prev;
    logic ext_trg_prev;
    logic user_out;
    logic [7:0] dac_first_low;
    logic [7:0] dac_second_low;
    logic [11:0] dac_first;
    logic [11:0] dac_second;
    logic [2:0] gain;
    logic [3:0] chan;
    logic [2:0] mode;
    logic [15:0] dout;
    logic [15:0] din;
    logic [11:0] result;
    logic not_ready;
    logic consumed;
    logic busy;
    logic done_flag;
    logic start;
  } idq_state_t;
  idq_state_t s;
  idq_state_t next_s;
  // ****************************************
  // Bus decode
  // ****************************************
  logic selected;
  logic [3:0] offset;
  logic rd_begin;
  logic wr_begin;
  logic [2:0] tick;
  logic [2:0] terminal;
  logic ref_tick;
  logic pacer_tick;
  logic soft_kick;
  logic ext_edge;
  logic trigger;
  logic sample_in;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [11:0] fifo_out_data;
  logic [1:0] ti;

  assign selected = !io_aen && (io_addr[9:4] == base_select); // see [RQ1]
  assign offset = io_addr[3:0]; // see [RQ1]
  assign rd_begin = selected && !io_read_n && s.prev_read_n;
  assign wr_begin = selected && !io_write_n && s.prev_write_n;
  assign io_data_oe = selected && !io_read_n;
  assign io_data_out = s.rd_data;
  assign ref_tick = s.ref_div == REF_DIV_LAST;
  assign ext_edge = external_trigger_input && !s.ext_trg_prev;
  assign soft_kick = wr_begin && (offset == OFS_CONVERSION_KICK); // see [RQ16]
  assign pacer_tick = terminal[2]; // see [RQ14]
  assign sample_in = adc_done && s.busy;
  assign fifo_pop = fifo_out_valid && s.consumed;

  // ****************************************
  // Counter clocking
  // ****************************************
  always_comb
  begin
    tick = '0;
    tick[0] = counter_clock_jumper ? (external_counter_clock && !s.ext_clk_prev)
                                   : ref_tick; // see [RQ15]
    tick[1] = ref_tick;
    tick[2] = terminal[1]; // see [RQ14]
    for (int i = 0; i < 3; i++)
    begin
      terminal[i] = tick[i] && (s.count[i] == 16'h0001);
    end
  end

  // ****************************************
  // Trigger selection
  // ****************************************
  always_comb
  begin
    trigger = 1'b0;
    case (s.mode) // see [RQ18]
      MODE_SOFT_POLL:
        trigger = !trigger_source_jumper && soft_kick; // see [RQ13]
      MODE_PACER_DMA, MODE_PACER_IRQ:
        trigger = trigger_source_jumper ? ext_edge : pacer_tick; // see [RQ13]
      default:
        trigger = 1'b0;
    endcase
    if (s.busy || s.start)
    begin
      trigger = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    ti = 2'(offset);
    next_s = s;
    next_s.prev_read_n = io_read_n;
    next_s.prev_write_n = io_write_n;
    next_s.ext_clk_prev = external_counter_clock;
    next_s.ext_trg_prev = external_trigger_input;
    next_s.din = digital_in; // see [RQ9]
    next_s.ref_div = ref_tick ? 5'h00 : s.ref_div + 5'h01;
    next_s.start = trigger; // see [RQ16]
    // Timer counters count down and reload at terminal count
    for (int i = 0; i < 3; i++)
    begin
      if (tick[i])
      begin
        next_s.count[i] = terminal[i] ? s.reload[i] : s.count[i] - 16'h0001;
      end
    end
    if (terminal[0])
    begin
      next_s.user_out = !s.user_out;
    end
    // Host reads
    if (rd_begin)
    begin
      case (offset)
        OFS_TIMER_COUNTER_ZERO, OFS_TIMER_COUNTER_ONE, OFS_TIMER_COUNTER_TWO:
        begin
          // Low byte read freezes the high byte for the next read
          if (s.rd_high[ti])
          begin
            next_s.rd_data = s.rd_hold[ti];
          end
          else
          begin
            next_s.rd_data = s.count[ti][7:0]; // see [RQ2]
            next_s.rd_hold[ti] = s.count[ti][15:8];
          end
          next_s.rd_high[ti] = !s.rd_high[ti];
        end
        OFS_ADC_LOW_DAC_FIRST_LOW:
          next_s.rd_data = s.result[7:0]; // see [RQ3]
        OFS_ADC_HIGH_DAC_FIRST_HIGH:
        begin
          next_s.rd_data = {3'h0, s.not_ready, s.result[11:8]}; // see [RQ3]
          if (!s.not_ready)
          begin
            next_s.consumed = 1'b1;
            // Flag waits again only if another sample is on its way
            next_s.not_ready = s.busy || fifo_out_valid; // see [RQ20]
          end
        end
        OFS_DIN_LOW_DAC_SECOND_LOW:
          next_s.rd_data = s.din[7:0]; // see [RQ9]
        OFS_DIN_HIGH_DAC_SECOND_HIGH:
          next_s.rd_data = s.din[15:8]; // see [RQ9]
        default:
          next_s.rd_data = RESERVED_READ; // see [RQ12] see [RQ21]
      endcase
    end
    // Host writes
    if (wr_begin)
    begin
      case (offset)
        OFS_TIMER_COUNTER_ZERO, OFS_TIMER_COUNTER_ONE, OFS_TIMER_COUNTER_TWO:
        begin
          if (s.wr_high[ti])
          begin
            next_s.reload[ti][15:8] = io_data_in; // see [RQ2]
            next_s.count[ti] = {io_data_in, s.reload[ti][7:0]};
          end
          else
          begin
            next_s.reload[ti][7:0] = io_data_in; // see [RQ2]
          end
          next_s.wr_high[ti] = !s.wr_high[ti];
        end
        OFS_TIMER_CONTROL_WORD:
        begin
          // Control word restarts the byte sequence of the named counter
          if (io_data_in[7:6] != 2'h3)
          begin
            next_s.wr_high[io_data_in[7:6]] = 1'b0; // see [RQ2]
            next_s.rd_high[io_data_in[7:6]] = 1'b0;
          end
        end
        OFS_ADC_LOW_DAC_FIRST_LOW:
          next_s.dac_first_low = io_data_in; // see [RQ5]
        OFS_ADC_HIGH_DAC_FIRST_HIGH:
          next_s.dac_first = {io_data_in[3:0], s.dac_first_low}; // see [RQ5] see [RQ7] see [RQ8]
        OFS_DIN_LOW_DAC_SECOND_LOW:
          next_s.dac_second_low = io_data_in; // see [RQ6]
        OFS_DIN_HIGH_DAC_SECOND_HIGH:
          next_s.dac_second = {io_data_in[3:0], s.dac_second_low}; // see [RQ6] see [RQ7]
        OFS_INPUT_GAIN_SELECT:
          next_s.gain = io_data_in[2:0]; // see [RQ12]
        OFS_INPUT_CHANNEL_SELECT:
          next_s.chan = io_data_in[3:0]; // see [RQ17]
        OFS_ACQUISITION_MODE:
          next_s.mode = io_data_in[2:0]; // see [RQ18]
        OFS_DIGITAL_OUT_LOW:
          next_s.dout[7:0] = io_data_in; // see [RQ19]
        OFS_DIGITAL_OUT_HIGH:
          next_s.dout[15:8] = io_data_in; // see [RQ19]
        default:
          next_s.rd_data = s.rd_data; // see [RQ21]
      endcase
    end
    // Conversion-done status, set wins over clear
    if (wr_begin && (offset == OFS_CONVERSION_IRQ_ACK))
    begin
      next_s.done_flag = 1'b0; // see [RQ11]
    end
    if (sample_in && adc_done_ready)
    begin
      next_s.busy = 1'b0;
      if (s.mode == MODE_PACER_IRQ)
      begin
        next_s.done_flag = 1'b1; // see [RQ10]
      end
    end
    // Result register takes the oldest buffered sample
    if (fifo_pop)
    begin
      next_s.result = fifo_out_data;
      next_s.consumed = 1'b0;
      next_s.not_ready = 1'b0; // see [RQ4]
    end
    // A held unread sample stays ready while the next conversion runs
    if (trigger)
    begin
      next_s.busy = 1'b1;
      if (next_s.consumed)
      begin
        next_s.not_ready = 1'b1; // see [RQ20]
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.prev_read_n <= 1'b1;
      s.prev_write_n <= 1'b1;
      s.consumed <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************
  // Result buffer
  // ****************************************
  idq_fifo #(
    .WIDTH(ADC_BITS),
    .DEPTH(RESULT_FIFO_DEPTH)
  ) u_result_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(sample_in),
    .in_ready(adc_done_ready),
    .in_data(adc_data),
    .out_valid(fifo_out_valid),
    .out_ready(s.consumed),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign adc_start = s.start;
  assign gain_code = s.gain;
  assign channel_select_bits = s.chan; // see [RQ17]
  assign dac_first_value = s.dac_first;
  assign dac_second_value = s.dac_second;
  assign digital_out = s.dout;
  assign user_counter_out = s.user_out;
  assign conversion_irq = s.done_flag; // see [RQ10]
  assign dma_request = (s.mode == MODE_PACER_DMA) && !s.not_ready && !s.consumed;
endmodule : idq_register_window

// ==== hw/idq_pkg.sv ====
package idq_pkg;
  // ****************************************
  // Address window
  // ****************************************
  localparam int unsigned IDQ_WINDOW_WORDS = 16;
  localparam logic [3:0] OFS_TIMER_COUNTER_ZERO = 4'h0;
  localparam logic [3:0] OFS_TIMER_COUNTER_ONE = 4'h1;
  localparam logic [3:0] OFS_TIMER_COUNTER_TWO = 4'h2;
  localparam logic [3:0] OFS_TIMER_CONTROL_WORD = 4'h3;
  localparam logic [3:0] OFS_ADC_LOW_DAC_FIRST_LOW = 4'h4;
  localparam logic [3:0] OFS_ADC_HIGH_DAC_FIRST_HIGH = 4'h5;
  localparam logic [3:0] OFS_DIN_LOW_DAC_SECOND_LOW = 4'h6;
  localparam logic [3:0] OFS_DIN_HIGH_DAC_SECOND_HIGH = 4'h7;
  localparam logic [3:0] OFS_CONVERSION_IRQ_ACK = 4'h8;
  localparam logic [3:0] OFS_INPUT_GAIN_SELECT = 4'h9;
  localparam logic [3:0] OFS_INPUT_CHANNEL_SELECT = 4'ha;
  localparam logic [3:0] OFS_ACQUISITION_MODE = 4'hb;
  localparam logic [3:0] OFS_CONVERSION_KICK = 4'hc;
  localparam logic [3:0] OFS_DIGITAL_OUT_LOW = 4'hd;
  localparam logic [3:0] OFS_DIGITAL_OUT_HIGH = 4'he;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned ADC_NOT_READY_BIT = 4;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_SOFT_POLL = 3'h1;
  localparam logic [2:0] MODE_PACER_DMA = 3'h2;
  localparam logic [2:0] MODE_PACER_IRQ = 3'h6;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned REF_HZ = 2_000_000;
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
  localparam logic [4:0] REF_DIV_LAST = 5'(REF_DIV - 1);
  localparam int unsigned RESULT_FIFO_DEPTH = 8;
  localparam int unsigned ADC_BITS = 12;
endpackage : idq_pkg

// ==== hw/idq_fifo.sv ====
`timescale 1ns/1ps
module idq_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } idq_fifo_state_t;
  idq_fifo_state_t s;
  idq_fifo_state_t next_s;
  logic push;
  logic pop;
  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop)
    begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : idq_fifo

// ==== verification/idq_checker.sv ====
`timescale 1ns/1ps
module idq_checker
  import idq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host bus
  input wire logic [9:0] io_addr,
  input wire logic io_aen,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic [7:0] io_data_in,
  input wire logic io_data_oe,
  input wire logic [5:0] base_select,
  // Converter and outputs
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic adc_done_ready,
  input wire logic conversion_irq,
  input wire logic [11:0] dac_first_value,
  input wire logic [11:0] dac_second_value,
  input wire logic [15:0] digital_out,
  input wire logic [3:0] channel_select_bits
);
  // ****
  // Bus decode helpers
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wn_q;
  logic hi1_q;
  logic [7:0] din_q;
  logic sel;
  logic wt;
  assign sel = !io_aen && io_addr[9:4] == base_select;
  assign wt = sel && !io_write_n && wn_q;
  always_ff @(posedge clk)
  begin
    wn_q <= io_write_n;
    din_q <= io_data_in;
    hi1_q <= wt && io_addr[3:0] == 4'h5;
  end
  // ****
  // Checks
  // ****
  a_oe_decode: assert property (io_data_oe == (sel && !io_read_n))
    else $error("read enable does not follow decode");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_irq_clear: assert property (wt && io_addr[3:0] == 4'h8 && !(adc_done && adc_done_ready)
    |=> !conversion_irq) else $error("done bit not cleared");
  a_dac_one: assert property (wt && io_addr[3:0] == 4'h5
    |=> dac_first_value[11:8] == din_q[3:0]) else $error("first high part wrong");
  a_dac_two: assert property (wt && io_addr[3:0] == 4'h7
    |=> dac_second_value[11:8] == din_q[3:0]) else $error("second high part wrong");
  a_dac_hold: assert property (!$stable(dac_first_value) |-> hi1_q)
    else $error("first output moved without high write");
  a_dout_low: assert property (wt && io_addr[3:0] == 4'hd
    |=> digital_out[7:0] == din_q) else $error("output low byte wrong");
  a_chan_sel: assert property (wt && io_addr[3:0] == 4'ha
    |=> channel_select_bits == din_q[3:0]) else $error("channel select wrong");
endmodule : idq_checker

// ==== verification/idq_adc_model.sv ====
`timescale 1ns/1ps
module idq_adc_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Converter pins
  input wire logic adc_start,
  input wire logic adc_done_ready,
  output logic adc_done,
  output logic [11:0] adc_data
);
  // ****
  // Converter with held result
  // ****
  int cnt;
  logic [11:0] val;
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= 0;
      adc_done <= 0;
      adc_data <= 12'h6b4;
      val <= 12'h94b;
    end
    else if (adc_done && adc_done_ready)
    begin
      adc_done <= 0;
      adc_data <= ~adc_data;
    end
    else if (adc_start)
      cnt <= LAT;
    else if (cnt == 1)
    begin
      cnt <= 0;
      adc_done <= 1;
      adc_data <= val;
      val <= val + 12'h111;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : idq_adc_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  logic [9:0] io_addr;
  logic io_aen;
  logic io_read_n;
  logic io_write_n;
  logic [7:0] io_data_in;
  logic [7:0] io_data_out;
  logic io_data_oe;
  logic [5:0] base_select;
  logic trigger_source_jumper;
  logic counter_clock_jumper;
  logic external_counter_clock;
  logic user_counter_out;
  logic external_trigger_input;
  logic adc_start;
  logic adc_done;
  logic adc_done_ready;
  logic [11:0] adc_data;
  logic [2:0] gain_code;
  logic [3:0] channel_select_bits;
  logic [11:0] dac_first_value;
  logic [11:0] dac_second_value;
  logic [15:0] digital_in;
  logic [15:0] digital_out;
  logic conversion_irq;
  logic dma_request;
  logic [5:0] hb;
  int errors;
  int tests_run;
  idq_register_window dut (.clk, .rst, .io_addr, .io_aen, .io_read_n, .io_write_n, .io_data_in,
    .io_data_out, .io_data_oe, .base_select, .trigger_source_jumper, .counter_clock_jumper,
    .external_counter_clock, .user_counter_out, .external_trigger_input, .adc_start, .adc_done,
    .adc_done_ready, .adc_data, .gain_code, .channel_select_bits, .dac_first_value,
    .dac_second_value, .digital_in, .digital_out, .conversion_irq, .dma_request);
  idq_adc_model #(.LAT(8)) adc (.clk, .rst, .adc_start, .adc_done_ready, .adc_done, .adc_data);
  // ****
  // Bus tasks
  // ****
  task automatic conclude;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    io_addr = {hb, ofs};
    io_data_in = d;
    io_write_n = 0;
    @(negedge clk);
    io_write_n = 1;
    @(negedge clk);
  endtask : wr
  task automatic rdc(input string nm, input logic [3:0] ofs, input logic [7:0] e);
    io_addr = {hb, ofs};
    io_read_n = 0;
    @(negedge clk);
    chk("oe", 16'h1, {15'h0, io_data_oe});
    chk(nm, {8'h0, e}, {8'h0, io_data_out});
    io_read_n = 1;
    @(negedge clk);
  endtask : rdc
  function automatic logic hit(input int k);
    case (k)
      0: return conversion_irq;
      1: return dma_request;
      default: return !adc_done_ready;
    endcase
  endfunction : hit
  task automatic wait_for(input int k, input int lim);
    for (int i = 0; i < lim && hit(k) !== 1'b1; i++)
      @(negedge clk);
    if (hit(k) !== 1'b1)
    begin
      errors++;
      conclude;
    end
  endtask : wait_for
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    errors = 0;
    tests_run = 0;
    rst = 1;
    io_addr = 0;
    io_aen = 0;
    io_read_n = 1;
    io_write_n = 1;
    io_data_in = 0;
    base_select = 6'h22;
    hb = 6'h22;
    trigger_source_jumper = 0;
    counter_clock_jumper = 0;
    external_counter_clock = 0;
    external_trigger_input = 0;
    digital_in = 16'hc35a;
    repeat (20) @(negedge clk);
    rst = 0;
    @(negedge clk);
    counter_clock_jumper = 1;
    wr(4'h0, 8'h07);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    rdc("cnt0_lo", 4'h0, 8'h02);
    rdc("cnt0_hi", 4'h0, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      external_counter_clock = 1;
      @(negedge clk);
      external_counter_clock = 0;
      @(negedge clk);
    end
    chk("user_out", 16'h1, {15'h0, user_counter_out});
    rdc("adc_hi", 4'h5, 8'h00);
    rdc("rsvd3", 4'h3, 8'h00);
    for (int o = 8; o < 16; o++)
    begin
      rdc("rsvd", 4'(o), 8'h00);
    end
    rdc("din_lo", 4'h6, 8'h5a);
    rdc("din_hi", 4'h7, 8'hc3);
    wr(4'h4, 8'h34);
    wr(4'h5, 8'hf2);
    chk("dac1", 16'h0234, {4'h0, dac_first_value});
    wr(4'h5, 8'h01);
    chk("dac1_stale", 16'h0134, {4'h0, dac_first_value});
    wr(4'h6, 8'hab);
    chk("dac2_held", 16'h0000, {4'h0, dac_second_value});
    wr(4'h7, 8'hfc);
    chk("dac2", 16'h0cab, {4'h0, dac_second_value});
    wr(4'hd, 8'h81);
    wr(4'he, 8'h7e);
    chk("dout", 16'h7e81, digital_out);
    wr(4'ha, 8'hf9);
    chk("chan", 16'h0009, {12'h0, channel_select_bits});
    wr(4'h9, 8'hfc);
    chk("gain", 16'h0004, {13'h0, gain_code});
    wr(4'hf, 8'hff);
    io_aen = 1;
    wr(4'hd, 8'h00);
    io_aen = 0;
    hb = 6'h23;
    wr(4'hd, 8'h00);
    hb = 6'h22;
    chk("dout_kept", 16'h7e81, digital_out);
    wr(4'hb, 8'h01);
    wr(4'hc, 8'h00);
    rdc("busy", 4'h5, 8'h10);
    repeat (20) @(negedge clk);
    rdc("res_lo", 4'h4, 8'h4b);
    rdc("res_hi", 4'h5, 8'h09);
    trigger_source_jumper = 1;
    wr(4'hb, 8'h06);
    external_trigger_input = 1;
    wait_for(0, 100);
    chk("irq", 16'h1, {15'h0, conversion_irq});
    external_trigger_input = 0;
    wr(4'h8, 8'h5a);
    chk("irq_clr", 16'h0, {15'h0, conversion_irq});
    rdc("res2_lo", 4'h4, 8'h5c);
    rdc("res2_hi", 4'h5, 8'h0a);
    trigger_source_jumper = 0;
    wr(4'h1, 8'h02);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h02);
    wr(4'h2, 8'h00);
    wr(4'hb, 8'h02);
    wait_for(1, 2000);
    chk("dma", 16'h1, {15'h0, dma_request});
    wait_for(2, 4000);
    chk("full", 16'h0, {15'h0, adc_done_ready});
    wr(4'hb, 8'h00);
    rdc("q_lo", 4'h4, 8'h6d);
    rdc("q_hi", 4'h5, 8'h0b);
    rdc("q2_lo", 4'h4, 8'h7e);
    for (int i = 0; i < 8; i++)
    begin
      rdc("q_rd", 4'h5, {4'h0, 4'(12 + i)});
    end
    rdc("q_last", 4'h5, 8'h03);
    chk("drained", 16'h1, {15'h0, adc_done_ready});
    conclude;
  end
endmodule : tb
bind idq_register_window idq_checker u_chk (.clk, .rst, .io_addr, .io_aen, .io_read_n,
  .io_write_n, .io_data_in, .io_data_oe, .base_select, .adc_start, .adc_done, .adc_done_ready,
  .conversion_irq, .dac_first_value, .dac_second_value, .digital_out, .channel_select_bits);
